/* logic/aocr_pkg.sv */
// Package for the output and power configuration register bank.
// Assumes one core clock; register writes arrive as a plain strobe with address and data.
package aocr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [8:0] ADDR_DEV_INDEX    = 9'h005;
  localparam logic [8:0] ADDR_POWER_MODE   = 9'h008;
  localparam logic [8:0] ADDR_CLK_DIV      = 9'h00b;
  localparam logic [8:0] ADDR_ENHANCE      = 9'h00c;
  localparam logic [8:0] ADDR_OUT_MODE     = 9'h014;
  localparam logic [8:0] ADDR_OUT_ADJUST   = 9'h015;
  localparam logic [8:0] ADDR_OUT_PHASE    = 9'h016;
  localparam logic [8:0] ADDR_SER_CTRL     = 9'h021;
  localparam logic [8:0] ADDR_TRANSFER     = 9'h0ff;
  localparam logic [8:0] ADDR_RES_OVERRIDE = 9'h100;
  localparam logic [8:0] ADDR_USER_IO_TWO  = 9'h101;
  localparam logic [8:0] ADDR_USER_IO_THREE = 9'h102;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_OUT_MODE  = 8'h01;
  localparam logic [7:0] RST_OUT_PHASE = 8'h03;
  localparam logic [7:0] RST_SER_CTRL  = 8'h32;
  localparam logic [7:0] RST_DEV_INDEX = 8'h3f;

  // ==========================================================================
  // Field positions
  localparam int PM_PIN_FUNC_BIT = 5;
  localparam int CHOP_BIT        = 2;
  localparam int OM_IEEE_BIT     = 6;
  localparam int OM_INVERT_BIT   = 2;
  localparam int OM_TWOS_BIT     = 0;
  localparam int OA_TERM_HI      = 5;
  localparam int OA_TERM_LO      = 4;
  localparam int OA_DRIVE_BIT    = 0;
  localparam int PH_IN_HI        = 6;
  localparam int PH_IN_LO        = 4;
  localparam int PH_OUT_HI       = 3;
  localparam int PH_OUT_LO       = 0;
  localparam int SC_MODE_HI      = 6;
  localparam int SC_MODE_LO      = 4;
  localparam int SC_FRAME2_BIT   = 2;
  localparam int SC_BITS_HI      = 1;
  localparam int SC_BITS_LO      = 0;
  localparam int XFER_BIT        = 0;
  localparam int PULLDN_OFF_BIT  = 0;
  localparam int CMREF_PD_BIT    = 3;
  localparam int CLK_CHAN_HI     = 5;
  localparam int CLK_CHAN_LO     = 4;

  localparam logic [3:0] PH_OUT_MAX = 4'hb;
  localparam logic [1:0] BITS_12    = 2'h2;
  localparam logic [1:0] BITS_10    = 2'h3;

  // ==========================================================================
  // Power modes and serial modes
  typedef enum logic [1:0] {
    AOCR_PM_NORMAL  = 2'h0,
    AOCR_PM_PWRDN   = 2'h1,
    AOCR_PM_STANDBY = 2'h2,
    AOCR_PM_RESET   = 2'h3
  } aocr_pmode_t;

  typedef enum logic [2:0] {
    AOCR_SM_SDR_BIT  = 3'h0,
    AOCR_SM_SDR_BYTE = 3'h1,
    AOCR_SM_DDR_BIT  = 3'h2,
    AOCR_SM_DDR_BYTE = 3'h3,
    AOCR_SM_DDR_ONE  = 3'h4
  } aocr_smode_t;

  // Data clock multiplier in half units of the sample rate
  localparam logic [3:0] MULT_12_FAST = 4'h6;
  localparam logic [3:0] MULT_12_SLOW = 4'hc;
  localparam logic [3:0] MULT_10_FAST = 4'h5;
  localparam logic [3:0] MULT_10_SLOW = 4'ha;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       clk_gate;
    logic       dp_reset;
    logic       out_disable;
    logic       full_pwrdn;
    logic       chop_en;
    logic [7:0] rate_override;
  } aocr_core_ctl_t;

  typedef struct packed {
    logic       ieee_range;
    logic       invert;
    logic       twos_comp;
    logic [1:0] term_sel;
    logic       clk_drive_2x;
    logic [2:0] in_clk_phase;
    logic [3:0] dco_phase;
    logic [2:0] serial_mode;
    logic       frame_2x;
    logic [1:0] bits_sel;
    logic [3:0] dco_mult_half;
    logic       pulldown_off;
    logic       cmref_pd;
  } aocr_out_ctl_t;

endpackage

/* logic/aocr_regs.sv */
// Output and power configuration register bank of a quad converter.
// Assumes the serial control port has already been brought into the core
// clock domain and delivers one write strobe per byte with its address.
//
// Contract
// [RL1] Power pin enters full power-down if bit 5 set, standby otherwise.
// [RL2] Power mode 00 keeps every channel active.
// [RL3] Power mode 01 gates datapath clocks, resets datapath, disables outputs.
// [RL4] Power mode 10 gates datapath clocks and outputs without reset.
// [RL5] Power mode 11 resets datapath and outputs, not the control port.
// [RL6] Control port registers reset only by power-on reset.
// [RL7] Enhancement bit 2 enables first-stage chopping.
// [RL8] Output mode bit 6 selects reduced-range option, default standard option.
// [RL9] Output mode bit 2 inverts every serialized output bit.
// [RL10] Output mode bit 0 defaults set for twos complement, clear gives offset binary.
// [RL11] Output adjust bits 5:4 select driver termination.
// [RL12] Output adjust bit 0 doubles frame and data clock drive on selected clocks.
// [RL13] Termination selection overrides double drive.
// [RL14] Output phase bits 6:4 delay sampling 0 to 7 input clocks.
// [RL15] Host keeps input clock phase at most the divider value.
// [RL16] Output phase bits 3:0 shift data clock in 60 degree steps, reset 0011.
// [RL17] Serial mode field selects lane mode; register resets to 0x32.
// [RL18] Data clock multiplier follows resolution and lane mode.
// [RL19] Serial control bit 2 selects double framing; low field selects 12 or 10 bits.
// [RL20] Override register applies only when transfer bit 0 is set.
// [RL21] User I/O two bit 0 disables the data pin pull-down.
// [RL22] User I/O three bit 3 powers down the common mode generator.
// [RL23] All other registers take effect immediately on write.
// [RL24] Device index low four bits select channels for per-channel writes.
// [RL25] Host issues digital reset after an unstable power-up clock.
// [RL26] Port-domain values are registered into the sample domain before use.
`timescale 1ns/1ns

module aocr_regs
  import aocr_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wr_en,
  input  wire logic [8:0]           i_wr_addr,
  input  wire logic [7:0]           i_wr_data,
  input  wire logic [8:0]           i_rd_addr,
  input  wire logic                 i_power_down_pin,
  output logic      [7:0]           o_rd_data,
  output aocr_core_ctl_t            o_core_ctl,
  output aocr_out_ctl_t [NUM_CH-1:0] o_ch_ctl,
  output logic      [1:0]           o_clk_drive_2x
);

  if (NUM_CH != 4) begin : g_num_ch_check
    $error("aocr_regs supports four channels only");
  end

  // ==========================================================================
  // Shared decode
  function automatic logic [3:0] dco_mult(input logic [1:0] bits, input logic [2:0] mode);
    logic fast;
    fast = (mode == AOCR_SM_DDR_BIT) || (mode == AOCR_SM_DDR_BYTE);
    if (bits == BITS_10) begin
      dco_mult = fast ? MULT_10_FAST : MULT_10_SLOW;
    end else begin
      dco_mult = fast ? MULT_12_FAST : MULT_12_SLOW;
    end
  endfunction

  // ==========================================================================
  // Global registers
  logic [7:0] dev_index_q;
  logic [7:0] power_mode_q;
  logic [7:0] clk_div_q;
  logic [7:0] enhance_q;
  logic [7:0] ser_ctrl_q;
  logic [7:0] res_shadow_q;
  logic [7:0] res_active_q;
  logic [7:0] user_io_two_q;
  logic [7:0] user_io_three_q;
  logic [7:0] out_mode_q   [NUM_CH];
  logic [7:0] out_adjust_q [NUM_CH];
  logic [7:0] out_phase_q  [NUM_CH];
  logic [1:0] clk_adjust_q [2];

  // Only i_rst (power-on) resets these; power modes never touch them
  always_ff @(posedge i_core_clk) begin // RL6
    if (i_rst) begin
      dev_index_q     <= RST_DEV_INDEX;
      power_mode_q    <= RST_ZERO;
      clk_div_q       <= RST_ZERO;
      enhance_q       <= RST_ZERO;
      ser_ctrl_q      <= RST_SER_CTRL; // RL17
      user_io_two_q   <= RST_ZERO;
      user_io_three_q <= RST_ZERO;
      res_shadow_q    <= RST_ZERO;
    end else if (i_wr_en) begin // RL23
      if (i_wr_addr == ADDR_DEV_INDEX) begin
        dev_index_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_POWER_MODE) begin
        power_mode_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_CLK_DIV) begin
        clk_div_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_ENHANCE) begin
        enhance_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_SER_CTRL) begin
        ser_ctrl_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_RES_OVERRIDE) begin
        res_shadow_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_USER_IO_TWO) begin
        user_io_two_q <= i_wr_data;
      end else if (i_wr_addr == ADDR_USER_IO_THREE) begin
        user_io_three_q <= i_wr_data;
      end
    end
  end

  // ==========================================================================
  // Override applied on transfer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      res_active_q <= RST_ZERO;
    end else if (i_wr_en && i_wr_addr == ADDR_TRANSFER && i_wr_data[XFER_BIT]) begin
      res_active_q <= res_shadow_q; // RL20
    end
  end

  // ==========================================================================
  // Per-channel registers, steered by the device index
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        out_mode_q[c]   <= RST_OUT_MODE; // RL10
        out_adjust_q[c] <= RST_ZERO;
        out_phase_q[c]  <= RST_OUT_PHASE; // RL16
      end
    end else if (i_wr_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (dev_index_q[c]) begin // RL24
          if (i_wr_addr == ADDR_OUT_MODE) begin
            out_mode_q[c] <= i_wr_data;
          end else if (i_wr_addr == ADDR_OUT_ADJUST) begin
            out_adjust_q[c] <= i_wr_data;
          end else if (i_wr_addr == ADDR_OUT_PHASE) begin
            out_phase_q[c] <= i_wr_data;
          end
        end
      end
    end
  end

  // Clock output drive settings, steered by the clock channel bits
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      clk_adjust_q[0] <= 2'h0;
      clk_adjust_q[1] <= 2'h0;
    end else if (i_wr_en && i_wr_addr == ADDR_OUT_ADJUST) begin
      for (int k = 0; k < 2; k++) begin
        if (dev_index_q[CLK_CHAN_LO+k]) begin // RL12
          clk_adjust_q[k] <= {|i_wr_data[OA_TERM_HI:OA_TERM_LO], i_wr_data[OA_DRIVE_BIT]};
        end
      end
    end
  end

  // ==========================================================================
  // Readback of channel 0 view and global state
  always_comb begin
    o_rd_data = RST_ZERO;
    if (i_rd_addr == ADDR_DEV_INDEX) begin
      o_rd_data = dev_index_q;
    end else if (i_rd_addr == ADDR_POWER_MODE) begin
      o_rd_data = power_mode_q;
    end else if (i_rd_addr == ADDR_CLK_DIV) begin
      o_rd_data = clk_div_q;
    end else if (i_rd_addr == ADDR_ENHANCE) begin
      o_rd_data = enhance_q;
    end else if (i_rd_addr == ADDR_OUT_MODE) begin
      o_rd_data = out_mode_q[0];
    end else if (i_rd_addr == ADDR_OUT_ADJUST) begin
      o_rd_data = out_adjust_q[0];
    end else if (i_rd_addr == ADDR_OUT_PHASE) begin
      o_rd_data = out_phase_q[0];
    end else if (i_rd_addr == ADDR_SER_CTRL) begin
      o_rd_data = ser_ctrl_q;
    end else if (i_rd_addr == ADDR_RES_OVERRIDE) begin
      o_rd_data = res_shadow_q;
    end else if (i_rd_addr == ADDR_USER_IO_TWO) begin
      o_rd_data = user_io_two_q;
    end else if (i_rd_addr == ADDR_USER_IO_THREE) begin
      o_rd_data = user_io_three_q;
    end
  end

  // ==========================================================================
  // Power control, registered into the datapath domain
  aocr_core_ctl_t core_d;

  always_comb begin
    core_d               = '0;
    core_d.chop_en       = enhance_q[CHOP_BIT]; // RL7
    core_d.rate_override = res_active_q;
    if (i_power_down_pin) begin
      if (power_mode_q[PM_PIN_FUNC_BIT]) begin // RL1
        core_d.clk_gate    = 1'b1;
        core_d.dp_reset    = 1'b1;
        core_d.out_disable = 1'b1;
        core_d.full_pwrdn  = 1'b1;
      end else begin
        core_d.clk_gate    = 1'b1;
        core_d.out_disable = 1'b1;
      end
    end else begin
      case (aocr_pmode_t'(power_mode_q[1:0]))
        AOCR_PM_NORMAL: begin
          core_d.clk_gate = 1'b0; // RL2
        end
        AOCR_PM_PWRDN: begin
          core_d.clk_gate    = 1'b1; // RL3
          core_d.dp_reset    = 1'b1;
          core_d.out_disable = 1'b1;
          core_d.full_pwrdn  = 1'b1;
        end
        AOCR_PM_STANDBY: begin
          core_d.clk_gate    = 1'b1; // RL4
          core_d.out_disable = 1'b1;
        end
        AOCR_PM_RESET: begin
          core_d.dp_reset    = 1'b1; // RL5
          core_d.out_disable = 1'b1;
        end
        default: begin
          core_d.clk_gate = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_core_ctl <= '0;
    end else begin
      o_core_ctl <= core_d; // RL26
    end
  end

  // ==========================================================================
  // Per-channel output control, registered
  aocr_out_ctl_t [NUM_CH-1:0] ch_d;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_d[c]               = '0;
      ch_d[c].ieee_range    = out_mode_q[c][OM_IEEE_BIT]; // RL8
      ch_d[c].invert        = out_mode_q[c][OM_INVERT_BIT]; // RL9
      ch_d[c].twos_comp     = out_mode_q[c][OM_TWOS_BIT]; // RL10
      ch_d[c].term_sel      = out_adjust_q[c][OA_TERM_HI:OA_TERM_LO]; // RL11
      ch_d[c].clk_drive_2x  = out_adjust_q[c][OA_DRIVE_BIT] &&
                              (out_adjust_q[c][OA_TERM_HI:OA_TERM_LO] == 2'h0); // RL13
      // Host keeps this at or below the divider setting
      ch_d[c].in_clk_phase  = out_phase_q[c][PH_IN_HI:PH_IN_LO]; // RL14 RL15
      ch_d[c].dco_phase     = (out_phase_q[c][PH_OUT_HI:PH_OUT_LO] > PH_OUT_MAX) ?
                              PH_OUT_MAX : out_phase_q[c][PH_OUT_HI:PH_OUT_LO]; // RL16
      ch_d[c].serial_mode   = ser_ctrl_q[SC_MODE_HI:SC_MODE_LO]; // RL17
      ch_d[c].frame_2x      = ser_ctrl_q[SC_FRAME2_BIT]; // RL19
      ch_d[c].bits_sel      = ser_ctrl_q[SC_BITS_HI:SC_BITS_LO]; // RL19
      ch_d[c].dco_mult_half = dco_mult(ser_ctrl_q[SC_BITS_HI:SC_BITS_LO],
                                       ser_ctrl_q[SC_MODE_HI:SC_MODE_LO]); // RL18
      ch_d[c].pulldown_off  = user_io_two_q[PULLDN_OFF_BIT]; // RL21
      ch_d[c].cmref_pd      = user_io_three_q[CMREF_PD_BIT]; // RL22
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ch_ctl       <= '0;
      o_clk_drive_2x <= 2'h0;
    end else begin
      o_ch_ctl <= ch_d; // RL26
      for (int k = 0; k < 2; k++) begin
        o_clk_drive_2x[k] <= clk_adjust_q[k][0] && !clk_adjust_q[k][1]; // RL12 RL13
      end
    end
  end

endmodule

/* tb/aocr_regs_props.sv */
// Assertion checker for the output and power configuration register bank.
// Assumes one core clock and the synchronous active-high reset of the bank.
`timescale 1ns/1ns

module aocr_regs_props
  import aocr_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic                      i_core_clk,
  input wire logic                      i_rst,
  input wire logic                      i_wr_en,
  input wire logic [8:0]                i_wr_addr,
  input wire logic [7:0]                i_wr_data,
  input wire logic [8:0]                i_rd_addr,
  input wire logic                      i_power_down_pin,
  input wire logic [7:0]                o_rd_data,
  input wire aocr_core_ctl_t            o_core_ctl,
  input wire aocr_out_ctl_t [NUM_CH-1:0] o_ch_ctl,
  input wire logic [1:0]                o_clk_drive_2x
);
  // ==========================================================================
  // Helper logic
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic [7:0] dev_q;
  logic       pm_wr;
  logic       om_wr;
  logic       adj_wr;
  logic       enh_wr;
  assign pm_wr  = i_wr_en && (i_wr_addr == ADDR_POWER_MODE);
  assign om_wr  = i_wr_en && (i_wr_addr == ADDR_OUT_MODE);
  assign adj_wr = i_wr_en && (i_wr_addr == ADDR_OUT_ADJUST);
  assign enh_wr = i_wr_en && (i_wr_addr == ADDR_ENHANCE);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dev_q <= RST_DEV_INDEX;
    end else if (i_wr_en && (i_wr_addr == ADDR_DEV_INDEX)) begin
      dev_q <= i_wr_data;
    end
  end

  function automatic logic [2:0] pm_exp(input logic [1:0] m);
    return (m == 2'h0) ? 3'b000 : (m == 2'h1) ? 3'b111 : (m == 2'h2) ? 3'b101 : 3'b011;
  endfunction

  function automatic logic [3:0] mult_exp(input logic [1:0] b, input logic [2:0] m);
    logic fast;
    fast = (m == 3'h2) || (m == 3'h3);
    if (b == BITS_12) return fast ? MULT_12_FAST : MULT_12_SLOW;
    return fast ? MULT_10_FAST : MULT_10_SLOW;
  endfunction

  // ==========================================================================
  // Assertions
  a_pm_decode: assert property (
    pm_wr && !i_power_down_pin ##1 !pm_wr && !i_power_down_pin |=>
    {o_core_ctl.clk_gate, o_core_ctl.dp_reset, o_core_ctl.out_disable} == pm_exp($past(i_wr_data[1:0], 2)))
    else $error("power mode decode wrong");
  a_chop_follow: assert property (
    enh_wr ##1 !enh_wr |=> o_core_ctl.chop_en == $past(i_wr_data[CHOP_BIT], 2))
    else $error("chop enable does not follow write");
  a_invert_follow: assert property (
    om_wr && dev_q[0] ##1 !om_wr |=> o_ch_ctl[0].invert == $past(i_wr_data[OM_INVERT_BIT], 2))
    else $error("output invert does not follow write");
  a_xfer_delay: assert property (
    $changed(o_core_ctl.rate_override) |->
    $past(i_wr_en && (i_wr_addr == ADDR_TRANSFER) && i_wr_data[XFER_BIT], 2))
    else $error("override applied without transfer");
  a_drive_double: assert property (
    adj_wr && i_wr_data[0] && (i_wr_data[5:4] == 2'h0) && (dev_q[5:4] == 2'h3) ##1 !adj_wr
    |=> o_clk_drive_2x == 2'h3)
    else $error("double drive not applied");
  a_term_wins: assert property (
    adj_wr && (i_wr_data[5:4] != 2'h0) && (dev_q[5:4] == 2'h3) ##1 !adj_wr |=> o_clk_drive_2x == 2'h0)
    else $error("termination does not cancel double drive");
  a_dco_clamp: assert property (
    o_ch_ctl[0].dco_phase <= PH_OUT_MAX)
    else $error("data clock phase out of range");
  a_mult_table: assert property (
    (o_ch_ctl[0].bits_sel == BITS_12) || (o_ch_ctl[0].bits_sel == BITS_10) |->
    o_ch_ctl[0].dco_mult_half == mult_exp(o_ch_ctl[0].bits_sel, o_ch_ctl[0].serial_mode))
    else $error("data clock multiplier wrong");
endmodule

bind aocr_regs aocr_regs_props #(.NUM_CH(NUM_CH)) u_props (
  .i_core_clk      (i_core_clk),
  .i_rst           (i_rst),
  .i_wr_en         (i_wr_en),
  .i_wr_addr       (i_wr_addr),
  .i_wr_data       (i_wr_data),
  .i_rd_addr       (i_rd_addr),
  .i_power_down_pin(i_power_down_pin),
  .o_rd_data       (o_rd_data),
  .o_core_ctl      (o_core_ctl),
  .o_ch_ctl        (o_ch_ctl),
  .o_clk_drive_2x  (o_clk_drive_2x)
);

/* tb/aocr_capture_model.sv */
// Behavioural model of the capture logic behind the serial outputs.
// Assumes it sees the core controls and the controls of channel 0.
`timescale 1ns/1ns

module aocr_capture_model
  import aocr_pkg::*;
(
  input  wire logic           i_core_clk,
  input  wire logic           i_rst,
  input  wire aocr_core_ctl_t i_core_ctl,
  input  wire aocr_out_ctl_t  i_ch_ctl,
  output logic                o_link_up,
  output logic [3:0]          o_bits_half
);
  // Link is usable only while clocks run and outputs are enabled
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_link_up   <= 1'b0;
      o_bits_half <= 4'h0;
    end else begin
      o_link_up   <= !(i_core_ctl.clk_gate || i_core_ctl.out_disable);
      o_bits_half <= i_ch_ctl.dco_mult_half;
    end
  end
endmodule

/* tb/aocr_regs_tb.sv */
// Self-checking bench for the output and power configuration register bank.
// Assumes the checker and capture model files are compiled before it.
`timescale 1ns/1ns

module aocr_regs_tb
  import aocr_pkg::*;
;
  typedef struct {int k; int ch; logic [15:0] v;} aocr_note_t;

  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 wr_en = 1'b0;
  logic [8:0]           wr_addr = 9'h000;
  logic [7:0]           wr_data = 8'h00;
  logic [8:0]           rd_addr = 9'h000;
  logic                 pin = 1'b0;
  logic [7:0]           rd_data;
  aocr_core_ctl_t       core_ctl;
  aocr_out_ctl_t [3:0]  ch_ctl;
  logic [1:0]           drive2x;
  logic                 link_up;
  logic [3:0]           bits_half;
  aocr_note_t           q[$];
  int                   error_cnt = 0;
  int                   n_compared = 0;
  logic [8:0] ra [9] = '{9'h008, 9'h00c, 9'h014, 9'h015, 9'h016, 9'h021, 9'h101, 9'h102, 9'h1ff};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h32, 8'h00, 8'h00, 8'h00};
  logic [3:0] pm [4] = '{4'h0, 4'hf, 4'ha, 4'h6};
  logic [7:0] sc [9] = '{8'h32, 8'h22, 8'h12, 8'h02, 8'h42, 8'h33, 8'h03, 8'h43, 8'h37};

  always #5 clk = ~clk;

  aocr_regs #(.NUM_CH(4)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_rd_addr(rd_addr), .i_power_down_pin(pin), .o_rd_data(rd_data), .o_core_ctl(core_ctl),
    .o_ch_ctl(ch_ctl), .o_clk_drive_2x(drive2x));

  aocr_capture_model u_cap (
    .i_core_clk(clk), .i_rst(rst), .i_core_ctl(core_ctl), .i_ch_ctl(ch_ctl[0]),
    .o_link_up(link_up), .o_bits_half(bits_half));

  // ==========================================================================
  // Tasks
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
  endtask

  task automatic note(input int k, input int c, input logic [15:0] v);
    aocr_note_t n;
    if (k == 0) rd_addr <= c[8:0];
    repeat (4) begin
      @(posedge clk);
      wr_en <= 1'b0;
    end
    n.k = k;
    n.ch = c;
    n.v = v;
    q.push_back(n);
  endtask

  task automatic cmp(input int k, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] result kind %0d expected %h seen %h", k, e, g);
    end
  endtask

  function automatic logic [3:0] mul(input logic [7:0] s);
    logic fast;
    fast = (s[6:4] == 3'h2) || (s[6:4] == 3'h3);
    if (s[1:0] == 2'h2) return fast ? 4'h6 : 4'hc;
    return fast ? 4'h5 : 4'ha;
  endfunction

  // ==========================================================================
  // Monitor
  always @(posedge clk) begin
    aocr_note_t    n;
    aocr_out_ctl_t c;
    logic [15:0]   g;
    while (q.size() > 0) begin
      n = q.pop_front();
      c = ch_ctl[n.ch[1:0]];
      case (n.k)
        0: g = 16'(rd_data);
        1: g = 16'({core_ctl.clk_gate, core_ctl.dp_reset, core_ctl.out_disable, core_ctl.full_pwrdn});
        2: g = 16'(core_ctl.chop_en);
        3: g = 16'(core_ctl.rate_override);
        4: g = 16'({c.ieee_range, c.invert, c.twos_comp, c.term_sel});
        5: g = 16'({c.in_clk_phase, c.dco_phase});
        6: g = 16'({c.serial_mode, c.frame_2x, c.bits_sel, c.dco_mult_half});
        7: g = 16'({c.pulldown_off, c.cmref_pd});
        8: g = 16'(drive2x);
        default: g = 16'({link_up, bits_half});
      endcase
      cmp(n.k, n.v, g);
    end
  end

  // ==========================================================================
  // Stimulus
  initial begin
    int         i;
    logic [7:0] d;
    logic [3:0] m;
    logic [2:0] p;
    void'($urandom(32'h5eed));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++) note(0, int'(ra[i]), 16'(rv[i]));
    note(6, 0, 16'h1a6);
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'h45;
      wr(ADDR_OUT_MODE, d);
      note(4, 0, 16'({d[6], d[2], d[0], 2'h0}));
    end
    wr(ADDR_DEV_INDEX, 8'h02);
    wr(ADDR_OUT_MODE, 8'h04);
    note(4, 1, 16'h08);
    note(4, 0, 16'({d[6], d[2], d[0], 2'h0}));
    wr(ADDR_DEV_INDEX, 8'h3f);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_POWER_MODE, 8'(i));
      note(1, 0, 16'(pm[i]));
      note(9, 0, 16'({i == 0, 4'h6}));
    end
    note(0, int'(ADDR_OUT_MODE), 16'(d));
    pin <= 1'b1;
    wr(ADDR_POWER_MODE, 8'h20);
    note(1, 0, 16'h0f);
    wr(ADDR_POWER_MODE, 8'h00);
    note(1, 0, 16'h0a);
    pin <= 1'b0;
    note(1, 0, 16'h00);
    wr(ADDR_ENHANCE, 8'h04);
    note(2, 0, 16'h1);
    wr(ADDR_ENHANCE, 8'h00);
    note(2, 0, 16'h0);
    wr(ADDR_OUT_ADJUST, 8'h01);
    note(8, 0, 16'h3);
    wr(ADDR_OUT_ADJUST, 8'h21);
    note(8, 0, 16'h0);
    note(4, 0, 16'({d[6], d[2], d[0], 2'h2}));
    wr(ADDR_OUT_ADJUST, 8'h00);
    wr(ADDR_CLK_DIV, 8'h07);
    for (i = 0; i < 4; i++) begin
      m = 4'($urandom % 12);
      p = 3'($urandom);
      wr(ADDR_OUT_PHASE, {1'b0, p, m});
      note(5, 0, 16'({p, m}));
    end
    wr(ADDR_OUT_PHASE, 8'h0f);
    note(5, 0, 16'h0b);
    for (i = 0; i < 9; i++) begin
      wr(ADDR_SER_CTRL, sc[i]);
      note(6, 0, 16'({sc[i][6:4], sc[i][2], sc[i][1:0], mul(sc[i])}));
    end
    wr(ADDR_RES_OVERRIDE, 8'h55);
    note(3, 0, 16'h00);
    wr(ADDR_TRANSFER, 8'h01);
    note(3, 0, 16'h55);
    wr(ADDR_USER_IO_TWO, 8'h01);
    wr(ADDR_USER_IO_THREE, 8'h08);
    note(7, 0, 16'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    note(0, int'(ADDR_OUT_PHASE), 16'h03);
    for (i = 0; i < 50 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) error_cnt++;
    stop_test();
  end
endmodule
